//--- verilog/fifo_flags.sv
// Single-clock FIFO with status flags, echo outputs and AXI4-Lite control
//
// Added by the designer: the register addresses and register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none

module fifo_flags #(
  parameter int DEPTH   = 16384,
  parameter int WIDTH   = 72
) (
  // Clock and reset
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  // AXI4-Lite write address, data and response
  input  wire logic [7:0]                  s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output var  logic                        s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output var  logic                        s_axi_wready,
  output var  logic [1:0]                  s_axi_bresp,
  output var  logic                        s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]                  s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output var  logic                        s_axi_arready,
  output var  logic [31:0]                 s_axi_rdata,
  output var  logic [1:0]                  s_axi_rresp,
  output var  logic                        s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  // Resets and straps
  input  wire logic                        master_reset_n,
  input  wire logic                        partial_reset_n,
  input  wire logic                        fall_through_mode,
  input  wire logic                        flag_timing_select,
  // Write port
  input  wire logic                        write_enable_n,
  input  wire logic [WIDTH-1:0]            write_data,
  // Read port
  input  wire logic                        read_enable_n,
  input  wire logic                        read_select_n,
  output var  logic [WIDTH-1:0]            read_data_out,
  // Serial offset loading
  input  wire logic                        serial_clock,
  input  wire logic                        serial_enable_n,
  input  wire logic                        serial_in,
  // Flags
  output var  logic                        full_flag_n,
  output var  logic                        input_ready_n,
  output var  logic                        empty_flag_n,
  output var  logic                        output_ready_n,
  output var  logic                        almost_full_n,
  output var  logic                        almost_empty_n,
  output var  logic                        half_full_n,
  // Echo outputs
  output var  logic                        echo_read_clock,
  output var  logic                        echo_read_enable_n
);
  import fifo_flags_pkg::*;

  localparam int PW = $clog2(DEPTH);
  localparam int CW = PW + 2;
  localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
  localparam logic [CW-1:0] HALF_C  = CW'(DEPTH / 2);
  localparam logic [CW-1:0] ONE_C   = CW'(1);

  // Byte-lane merge used by every writable register
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction : merge

  // Mask applied to data leaving through the read port
  function automatic logic [WIDTH-1:0] width_mask(input logic [1:0] code);
    logic [WIDTH-1:0] m;
    m = '1;
    if (code == WIDTH_36) begin
      m = WIDTH'({36{1'b1}});
    end else if (code == WIDTH_18) begin
      m = WIDTH'({18{1'b1}});
    end
    return m;
  endfunction : width_mask

  // Storage and pointers
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0]      wp_q, rp_q, mark_q;
  logic             ov_q;
  strap_set_t       strap_q;
  logic [31:0]      ctrl_q, eofs_q, fofs_q;
  logic             ne1_q, ne2_q, full1_q, empty1_q, empty2_q;
  logic             wr_evt_q, rd_evt_q, sclk_q;
  logic             aw_go_q, ar_go_q;

  // Pointer arithmetic and occupancy
  wire logic             retx      = ctrl_q[CTRL_RETX_BIT];
  wire logic [PW:0]      ref_ptr   = retx ? mark_q : rp_q;
  wire logic [CW-1:0]    fill_wr   = CW'(wp_q - ref_ptr);
  wire logic [CW-1:0]    fill_rd   = CW'(wp_q - rp_q);
  wire logic [CW-1:0]    ov_cnt    = (strap_q.fall_through && ov_q) ? ONE_C : '0;
  wire logic [CW-1:0]    occ_wr    = fill_wr + ov_cnt;
  wire logic [CW-1:0]    occ_rd    = fill_rd + ov_cnt;
  wire logic [CW-1:0]    top_c     = strap_q.fall_through ? DEPTH_C + ONE_C : DEPTH_C;
  wire logic [CW-1:0]    m_c       = CW'(fofs_q[PW:0]);
  wire logic [CW-1:0]    n_c       = CW'(eofs_q[PW:0]);
  wire logic             in_reset  = !master_reset_n || !partial_reset_n;

  // Flag conditions, active high
  wire logic mem_full  = fill_wr == DEPTH_C;
  wire logic full_c    = occ_wr == top_c;
  wire logic af_c      = occ_wr >= top_c - m_c;
  wire logic ae_c      = strap_q.fall_through ? occ_rd <= n_c + ONE_C
                                              : occ_rd <= n_c;
  wire logic hf_c      = strap_q.fall_through ? occ_rd > HALF_C + ONE_C
                                              : occ_rd > HALF_C;
  wire logic mem_ne    = fill_rd != '0;

  // Port actions
  wire logic wr_go     = !in_reset && !write_enable_n && !mem_full;
  wire logic rd_req    = !in_reset && !read_enable_n && !read_select_n;
  wire logic rd_std    = !strap_q.fall_through && rd_req && empty2_q && mem_ne;
  wire logic rd_fall_through_mode   = strap_q.fall_through && rd_req && ov_q;
  wire logic rd_last   = rd_std && fill_rd == ONE_C;
  wire logic load_fall_through_mode = strap_q.fall_through && !in_reset && ne2_q && mem_ne
                         && (!ov_q || rd_fall_through_mode);
  wire logic mem_pop   = rd_std || load_fall_through_mode;
  wire logic [WIDTH-1:0] mem_word = mem[rp_q[PW-1:0]] & width_mask(ctrl_q[CTRL_WIDTH_LSB +: 2]);

  // Serial offset loading
  wire logic s_shift   = serial_clock && !sclk_q && !serial_enable_n;

  // Bus decode
  wire logic aw_take   = s_axi_awvalid && s_axi_wvalid && !aw_go_q && !s_axi_bvalid;
  wire logic ar_take   = s_axi_arvalid && !ar_go_q && !s_axi_rvalid;
  wire logic w_ctrl    = aw_go_q && s_axi_awaddr == CTRL_OFS;
  wire logic w_eofs    = aw_go_q && s_axi_awaddr == EMPTY_OFS_OFS;
  wire logic w_fofs    = aw_go_q && s_axi_awaddr == FULL_OFS_OFS;
  wire logic w_hit     = w_ctrl || w_eofs || w_fofs;
  wire flag_set_t flags_now = '{half_full: !half_full_n, almost_empty: !almost_empty_n,
                               almost_full: !almost_full_n, empty: !empty2_q,
                               full: full1_q};
  wire logic [31:0] status_w = {25'h0, strap_q, flags_now};
  logic [31:0] rd_mux;
  logic        rd_hit;

  // Read data selection
  always_comb begin
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      CTRL_OFS:      rd_mux = {ctrl_q[31:2], 1'b0, ctrl_q[0]};
      EMPTY_OFS_OFS: rd_mux = eofs_q;
      FULL_OFS_OFS:  rd_mux = fofs_q;
      STATUS_OFS:    rd_mux = status_w;
      LEVEL_OFS:     rd_mux = 32'(occ_rd);
      default: begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  // Memory write
  always_ff @(posedge aclk) begin
    if (wr_go) begin
      mem[wp_q[PW-1:0]] <= write_data;
    end
  end

  // Straps captured while master reset is held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strap_q <= '0;
    end else if (!master_reset_n) begin
      strap_q <= '{fall_through: fall_through_mode, sync_flags: flag_timing_select};
    end
  end

  // Pointers, output register and mark
  always_ff @(posedge aclk) begin
    if (!aresetn || in_reset) begin
      wp_q   <= '0;
      rp_q   <= '0;
      mark_q <= '0;
      ov_q   <= 1'b0;
    end else begin
      if (wr_go) begin
        wp_q <= wp_q + 1'b1;
      end
      if (mem_pop) begin
        rp_q <= rp_q + 1'b1;
      end
      if (w_ctrl && s_axi_wstrb[0] && s_axi_wdata[CTRL_MARK_BIT]) begin
        mark_q <= rp_q;
      end
      if (load_fall_through_mode) begin
        ov_q <= 1'b1;
      end else if (rd_fall_through_mode) begin
        ov_q <= 1'b0;
      end
    end
  end

  // Read data register; last word stays after the final read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      read_data_out <= '0;
    end else if (mem_pop) begin
      read_data_out <= mem_word;
    end
  end

  // Flag register stages
  always_ff @(posedge aclk) begin
    if (!aresetn || in_reset) begin
      full1_q        <= 1'b0;
      full_flag_n    <= 1'b1;
      input_ready_n  <= 1'b0;
      ne1_q          <= 1'b0;
      ne2_q          <= 1'b0;
      empty1_q       <= 1'b0;
      empty2_q       <= 1'b0;
      empty_flag_n   <= 1'b0;
      output_ready_n <= 1'b1;
    end else begin
      full1_q        <= full_c;
      full_flag_n    <= strap_q.fall_through || !full1_q;
      input_ready_n  <= strap_q.fall_through && full1_q;
      ne1_q          <= mem_ne;
      ne2_q          <= ne1_q;
      empty1_q       <= mem_ne && !rd_last;
      empty2_q       <= empty1_q && mem_ne && !rd_last;
      empty_flag_n   <= strap_q.fall_through || (empty1_q && mem_ne && !rd_last);
      output_ready_n <= !(strap_q.fall_through && (load_fall_through_mode || (ov_q && !rd_fall_through_mode)));
    end
  end

  // Half-full flag, and programmable flags when sync_flags is clear, driven by the previous cycle's event
  always_ff @(posedge aclk) begin
    if (!aresetn || in_reset) begin
      wr_evt_q       <= 1'b0;
      rd_evt_q       <= 1'b0;
      almost_full_n  <= 1'b1;
      almost_empty_n <= 1'b0;
      half_full_n    <= 1'b1;
    end else begin
      wr_evt_q <= wr_go;
      rd_evt_q <= mem_pop || rd_fall_through_mode;
      if (strap_q.sync_flags) begin
        almost_full_n  <= !af_c;
        almost_empty_n <= !ae_c;
      end else begin
        if (wr_evt_q && af_c) begin
          almost_full_n <= 1'b0;
        end else if (rd_evt_q && !af_c) begin
          almost_full_n <= 1'b1;
        end
        if (rd_evt_q && ae_c) begin
          almost_empty_n <= 1'b0;
        end else if (wr_evt_q && !ae_c) begin
          almost_empty_n <= 1'b1;
        end
      end
      if (wr_evt_q && hf_c) begin
        half_full_n <= 1'b0;
      end else if (rd_evt_q && !hf_c) begin
        half_full_n <= 1'b1;
      end
    end
  end

  // Echo outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      echo_read_clock    <= 1'b0;
      echo_read_enable_n <= 1'b1;
    end else begin
      echo_read_clock    <= !echo_read_clock;
      echo_read_enable_n <= !(rd_std || rd_fall_through_mode);
    end
  end

  // Offset registers and control, from bus or serial loader
  always_ff @(posedge aclk) begin
    if (!aresetn || !master_reset_n) begin
      sclk_q <= 1'b0;
      ctrl_q <= CTRL_RESET;
      eofs_q <= DEF_OFFSET;
      fofs_q <= DEF_OFFSET;
    end else begin
      sclk_q <= serial_clock;
      if (s_shift) begin
        {eofs_q[PW:0], fofs_q[PW:0]} <= {eofs_q[PW-1:0], fofs_q[PW:0], serial_in};
      end else begin
        if (w_ctrl) begin
          ctrl_q <= merge(ctrl_q, s_axi_wdata, s_axi_wstrb) & 32'h0000_000D;
        end
        if (w_eofs) begin
          eofs_q <= merge(eofs_q, s_axi_wdata, s_axi_wstrb) & 32'(DEPTH - 1);
        end
        if (w_fofs) begin
          fofs_q <= merge(fofs_q, s_axi_wdata, s_axi_wstrb) & 32'(DEPTH - 1);
        end
      end
    end
  end

  // AXI4-Lite write channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_go_q       <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      aw_go_q       <= aw_take;
      s_axi_awready <= aw_take;
      s_axi_wready  <= aw_take;
      if (aw_go_q) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= w_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // AXI4-Lite read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ar_go_q       <= 1'b0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      ar_go_q       <= ar_take;
      s_axi_arready <= ar_take;
      if (ar_go_q) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux;
        s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule : fifo_flags

`default_nettype wire

//--- verilog/fifo_flags_pkg.sv
// Shared constants, register map and carrier types of the FIFO flag block
package fifo_flags_pkg;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS      = 8'h00;
  localparam logic [7:0] EMPTY_OFS_OFS = 8'h04;
  localparam logic [7:0] FULL_OFS_OFS  = 8'h08;
  localparam logic [7:0] STATUS_OFS    = 8'h0C;
  localparam logic [7:0] LEVEL_OFS     = 8'h10;

  // Control register fields
  localparam int CTRL_RETX_BIT  = 0;
  localparam int CTRL_MARK_BIT  = 1;
  localparam int CTRL_WIDTH_LSB = 2;

  // Output width codes
  localparam logic [1:0] WIDTH_72 = 2'h0;
  localparam logic [1:0] WIDTH_36 = 2'h1;
  localparam logic [1:0] WIDTH_18 = 2'h2;

  // Reset values
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
  localparam logic [31:0] DEF_OFFSET    = 32'h0000_007F;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Flag set carried into the status register (active high meanings)
  typedef struct packed {
    logic half_full;
    logic almost_empty;
    logic almost_full;
    logic empty;
    logic full;
  } flag_set_t;

  // Configuration caught at master reset
  typedef struct packed {
    logic fall_through;
    logic sync_flags;
  } strap_set_t;

endpackage : fifo_flags_pkg

//--- tb/fifo_flags_props.sv
// Concurrent checks on the FIFO flag block ports
`timescale 1ns/100ps
`default_nettype none
module fifo_flags_props #(
  parameter int DEPTH = 16384,
  parameter int WIDTH = 72
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Port controls
  input wire logic write_enable_n,
  input wire logic read_enable_n,
  input wire logic read_select_n,
  input wire logic master_reset_n,
  input wire logic partial_reset_n,
  input wire logic fall_through_mode,
  // Bus handshake
  input wire logic s_axi_awready,
  // Flags and echoes
  input wire logic full_flag_n,
  input wire logic input_ready_n,
  input wire logic empty_flag_n,
  input wire logic output_ready_n,
  input wire logic almost_full_n,
  input wire logic almost_empty_n,
  input wire logic half_full_n,
  input wire logic echo_read_clock,
  input wire logic echo_read_enable_n
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // A write request one to four edges back
  sequence s_recent_wr;
    $past(write_enable_n, 1) == 1'b0 || $past(write_enable_n, 2) == 1'b0 ||
    $past(write_enable_n, 3) == 1'b0 || $past(write_enable_n, 4) == 1'b0;
  endsequence
  // A write or a register write one to four edges back
  sequence s_recent_cause;
    $past(write_enable_n, 1) == 1'b0 || $past(write_enable_n, 2) == 1'b0 ||
    $past(write_enable_n, 3) == 1'b0 || $past(write_enable_n, 4) == 1'b0 ||
    $past(s_axi_awready, 1) || $past(s_axi_awready, 2) ||
    $past(s_axi_awready, 3) || $past(s_axi_awready, 4);
  endsequence
  // Both read enables low at the previous edge
  sequence s_true_rd;
    $past(read_enable_n) == 1'b0 && $past(read_select_n) == 1'b0;
  endsequence

  a_reset_flags: assert property (
    $rose(aresetn) |-> full_flag_n && !empty_flag_n && half_full_n && echo_read_enable_n)
    else $error("flags wrong after reset");
  a_echo_clock: assert property (
    $past(aresetn) |-> echo_read_clock != $past(echo_read_clock))
    else $error("echo read clock did not toggle");
  a_echo_read: assert property (
    !echo_read_enable_n |-> s_true_rd)
    else $error("echo read enable low without a read");
  a_full_cause: assert property (
    $fell(full_flag_n) |-> s_recent_cause)
    else $error("full flag fell without a write");
  a_empty_cause: assert property (
    $rose(empty_flag_n) && !fall_through_mode |-> s_recent_wr)
    else $error("empty flag rose without a write");
  a_ready_rise: assert property (
    $rose(output_ready_n) && $past(master_reset_n) && $past(partial_reset_n) |-> s_true_rd)
    else $error("output ready released without a read");
  a_half_cause: assert property (
    $fell(half_full_n) |-> s_recent_wr)
    else $error("half full fell without a write");
  a_afull_cause: assert property (
    $fell(almost_full_n) |-> s_recent_cause)
    else $error("almost full fell without a write");
  a_aempty_cause: assert property (
    $rose(almost_empty_n) |-> s_recent_wr)
    else $error("almost empty rose without a write");
  a_mode_excl: assert property (
    !(!full_flag_n && input_ready_n) && !(!empty_flag_n && !output_ready_n))
    else $error("standard and fall-through flags both active");
endmodule : fifo_flags_props

bind fifo_flags fifo_flags_props #(.DEPTH(DEPTH), .WIDTH(WIDTH)) i_fifo_flags_props (
  .aclk, .aresetn, .write_enable_n, .read_enable_n, .read_select_n, .master_reset_n,
  .partial_reset_n, .fall_through_mode, .s_axi_awready, .full_flag_n, .input_ready_n,
  .empty_flag_n,
  .output_ready_n, .almost_full_n, .almost_empty_n, .half_full_n, .echo_read_clock,
  .echo_read_enable_n);
`default_nettype wire

//--- tb/read_host.sv
// Reading host that drains the FIFO with random stalls
`timescale 1ns/100ps
`default_nettype none
module read_host (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Bench control
  input  wire logic run,
  // FIFO read side
  input  wire logic empty_flag_n,
  output var  logic read_enable_n = 1'b1,
  output var  logic read_select_n = 1'b1
);
  integer     rseed = 32'h21d0;
  logic [1:0] pick;

  // Reads only while data shows; select is sometimes withheld
  always @(posedge aclk) begin
    pick = 2'($random(rseed));
    read_enable_n <= !(aresetn && run && empty_flag_n && pick[0]);
    read_select_n <= &pick;
  end
endmodule : read_host
`default_nettype wire

//--- tb/fifo_flags_test.sv
// Self-checking bench for the FIFO flag block in both modes
`timescale 1ns/100ps
`default_nettype none
module fifo_flags_test;
  import fifo_flags_pkg::*;
  localparam int DEPTH = 16;
  localparam int MOFS  = 4;
  localparam int NOFS  = 2;
  logic aclk = 1'b0, aresetn = 1'b0, master_reset_n = 1'b0, partial_reset_n = 1'b1;
  logic fall_through_mode = 1'b0, flag_timing_select = 1'b1, run = 1'b0, std_mode = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, write_enable_n = 1'b1;
  logic serial_clock = 1'b0, serial_enable_n = 1'b1, serial_in = 1'b0;
  logic [71:0] write_data = 72'h0, read_data_out, d, mask = {72{1'b1}};
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic read_enable_n, read_select_n, full_flag_n, input_ready_n, empty_flag_n;
  logic output_ready_n, almost_full_n, almost_empty_n, half_full_n;
  logic echo_read_clock, echo_read_enable_n;
  logic [71:0] dq[$];
  logic [31:0] rq[$];
  integer seed = 32'h21d0;
  int n_fail = 0;
  int compares = 0;

  fifo_flags #(.DEPTH(DEPTH), .WIDTH(72)) i_fifo_flags (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .master_reset_n, .partial_reset_n, .fall_through_mode,
    .flag_timing_select, .write_enable_n, .write_data, .read_enable_n, .read_select_n,
    .read_data_out, .serial_clock, .serial_enable_n, .serial_in, .full_flag_n,
    .input_ready_n, .empty_flag_n, .output_ready_n, .almost_full_n, .almost_empty_n,
    .half_full_n, .echo_read_clock, .echo_read_enable_n);
  read_host i_read_host (.aclk, .aresetn, .run, .empty_flag_n, .read_enable_n,
    .read_select_n);

  // Clock and watchdog
  initial begin
    forever #12.5 aclk = ~aclk;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    stop_test();
  end

  task automatic chk(input string n, input logic [71:0] e, input logic [71:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask : chk

  task automatic stop_test();
    $display("mismatches %0d of %0d compares", n_fail, compares);
    if (n_fail == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test

  // Bus write: both channels offered, response awaited
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", er, s_axi_bresp);
  endtask : axi_wr

  // Bus read: expected data noted for the watcher
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ev, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    rq.push_back(ev);
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk("rresp", er, s_axi_rresp);
  endtask : axi_rd

  task automatic wr(input logic [71:0] v, input bit keep);
    @(posedge aclk);
    write_enable_n <= 1'b0;
    write_data <= v;
    if (keep) dq.push_back(v & mask);
    @(posedge aclk);
    write_enable_n <= 1'b1;
  endtask : wr

  // Serial offset load, first bit lands in the empty offset top; clock idles low
  task automatic ser_ld(input logic [9:0] v);
    for (int b = 9; b >= 0; b--) begin
      @(posedge aclk);
      serial_enable_n <= 1'b0;
      serial_in <= v[b];
      serial_clock <= 1'b1;
      @(posedge aclk);
      serial_clock <= 1'b0;
    end
    @(posedge aclk);
    serial_enable_n <= 1'b1;
  endtask : ser_ld

  task automatic flags(input int k);
    repeat (4) @(posedge aclk);
    chk("full", !(k >= DEPTH), full_flag_n);
    chk("empty", k > 0, empty_flag_n);
    chk("almost_full", !(k >= DEPTH - MOFS), almost_full_n);
    chk("almost_empty", k > NOFS, almost_empty_n);
    chk("half_full", !(k > DEPTH / 2), half_full_n);
  endtask : flags

  // Result watcher takes the oldest note when a result shows
  always @(posedge aclk) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1 && rq.size() > 0)
      chk("rdata", rq.pop_front(), s_axi_rdata);
    if (std_mode && echo_read_enable_n === 1'b0)
      chk("read_data", dq.size() > 0 ? dq.pop_front() : 72'hX, read_data_out);
  end

  // Main sequence
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    master_reset_n <= 1'b1;
    flags(0);
    axi_rd(STATUS_OFS, 32'h0000_002A, RESP_OKAY);
    axi_rd(FULL_OFS_OFS, DEF_OFFSET, RESP_OKAY);
    axi_wr(FULL_OFS_OFS, MOFS, RESP_OKAY);
    axi_wr(EMPTY_OFS_OFS, NOFS, RESP_OKAY);
    axi_wr(CTRL_OFS, 32'h0000_0006, RESP_OKAY);
    axi_rd(CTRL_OFS, 32'h0000_0004, RESP_OKAY);
    axi_wr(8'h40, 32'h1234_5678, RESP_SLVERR);
    axi_rd(8'h40, 32'h0, RESP_SLVERR);
    mask = {36'h0, {36{1'b1}}};
    for (int i = 1; i <= DEPTH + 1; i++) begin
      d = {8'($random(seed)), 32'($random(seed)), 32'($random(seed))};
      wr(d, i <= DEPTH);
      flags(i > DEPTH ? DEPTH : i);
    end
    axi_rd(LEVEL_OFS, DEPTH, RESP_OKAY);
    run <= 1'b1;
    for (int t = 0; t < 600 && dq.size() > 0; t++) @(posedge aclk);
    run <= 1'b0;
    chk("drain_left", 72'h0, 72'(dq.size()));
    flags(0);
    axi_wr(CTRL_OFS, 32'h0000_0005, RESP_OKAY);
    repeat (4) @(posedge aclk);
    chk("retx_full", 1'b0, full_flag_n);
    axi_wr(CTRL_OFS, 32'h0000_0004, RESP_OKAY);
    std_mode = 1'b0;
    fall_through_mode <= 1'b1;
    flag_timing_select <= 1'b0;
    master_reset_n <= 1'b0;
    repeat (2) @(posedge aclk);
    master_reset_n <= 1'b1;
    ser_ld({5'(NOFS), 5'(MOFS)});
    axi_rd(STATUS_OFS, 32'h0000_004A, RESP_OKAY);
    for (int i = 1; i <= DEPTH + 1; i++) begin
      d = {8'($random(seed)), 32'($random(seed)), 32'($random(seed))};
      wr(d, 1'b0);
      for (int t = 0; i == 1 && t < 10 && output_ready_n !== 1'b0; t++) @(posedge aclk);
      if (i == 1) begin
        chk("output_ready", 1'b0, output_ready_n);
        chk("first_word", d, read_data_out);
      end
      repeat (4) @(posedge aclk);
      chk("input_ready", i > DEPTH, input_ready_n);
      chk("half_full", !(i >= DEPTH / 2 + 2), half_full_n);
      chk("almost_full", !(i >= DEPTH + 1 - MOFS), almost_full_n);
      chk("almost_empty", i > NOFS + 1, almost_empty_n);
    end
    run <= 1'b1;
    for (int t = 0; t < 600 && output_ready_n !== 1'b1; t++) @(posedge aclk);
    run <= 1'b0;
    repeat (4) @(posedge aclk);
    chk("output_ready", 1'b1, output_ready_n);
    chk("input_ready", 1'b0, input_ready_n);
    chk("almost_full", 1'b1, almost_full_n);
    chk("almost_empty", 1'b0, almost_empty_n);
    // Partial reset drops stored words, keeps settings
    for (int i = 0; i < 3; i++) wr(72'(i + 1), 1'b0);
    partial_reset_n <= 1'b0;
    repeat (2) @(posedge aclk);
    partial_reset_n <= 1'b1;
    repeat (4) @(posedge aclk);
    chk("output_ready", 1'b1, output_ready_n);
    axi_rd(LEVEL_OFS, 32'h0000_0000, RESP_OKAY);
    stop_test();
  end
endmodule : fifo_flags_test
`default_nettype wire
